/* File: verilog/tru_timer.sv */
// Three-channel reload timer with channel 2 input capture
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tru_timer (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic mult_change_i,
    input wire logic module_stop_i,
    input wire logic ext_timer_input_i,
    input wire tru_pkg::tru_bus_req_type bus_i,
    output logic [31:0] rdata_o,
    output logic [2:0] underflow_irq_o,
    output logic capture_irq_o
);
    tru_pkg::tru_state_type s_q;
    tru_pkg::tru_state_type s_d;

    logic rise;
    logic fall;
    logic [3:0] div_en;
    logic [tru_pkg::NCH-1:0] tick;
    logic [tru_pkg::NCH-1:0] uflow_ev;
    logic cap_ev;

    // ----------------------------------------
    // Pin edges and divided enables
    // ----------------------------------------
    // Only the synchronised second and third stages are compared
    assign rise = s_q.ext_s2 & ~s_q.ext_s3;
    assign fall = ~s_q.ext_s2 & s_q.ext_s3;
    assign div_en[0] = (s_q.pre & tru_pkg::PRE_DIV4_M) == tru_pkg::PRE_DIV4_M;
    assign div_en[1] = (s_q.pre & tru_pkg::PRE_DIV16_M)
        == tru_pkg::PRE_DIV16_M;
    assign div_en[2] = (s_q.pre & tru_pkg::PRE_DIV64_M)
        == tru_pkg::PRE_DIV64_M;
    assign div_en[3] = s_q.pre == tru_pkg::PRE_DIV256_M;

    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r, input logic f);
        logic hit;
        hit = 1'b0;
        if (sel[1]) begin
            hit = r | f;
        end else if (sel == tru_pkg::EDGE_FALL) begin
            hit = f;
        end else begin
            hit = r;
        end
        return hit;
    endfunction

    genvar g;
    generate
        for (g = 0; g < tru_pkg::NCH; g++) begin : g_tick
            logic [2:0] psc;
            logic [1:0] edg;
            assign psc = s_q.ctrl[g][tru_pkg::B_PSC_HI:0];
            assign edg = s_q.ctrl[g][tru_pkg::B_EDGE_HI:tru_pkg::B_EDGE_LO];
            always_comb begin
                unique case (psc)
                    tru_pkg::PSC_DIV4: tick[g] = div_en[0];
                    tru_pkg::PSC_DIV16: tick[g] = div_en[1];
                    tru_pkg::PSC_DIV64: tick[g] = div_en[2];
                    tru_pkg::PSC_DIV256: tick[g] = div_en[3];
                    // Edge field is consulted here and by the channel 2 capture
                    tru_pkg::PSC_EXT: tick[g] = edge_hit(edg, rise, fall);
                    // Prohibited codes simply stop counting
                    default: tick[g] = 1'b0;
                endcase
            end
            // A tick at zero is the underflow; the count reloads from rconst
            assign uflow_ev[g] = s_q.run[g] & tick[g]
                & (s_q.cnt[g] == tru_pkg::ZERO32);
        end
    endgenerate

    // Capture enabled when field is 1x; 01 is treated as off
    assign cap_ev = s_q.ctrl[2][tru_pkg::B_CAPE_HI]
        & edge_hit(s_q.ctrl[2][tru_pkg::B_EDGE_HI:tru_pkg::B_EDGE_LO],
                   rise, fall);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] off;
        logic [1:0] ch;
        logic [3:0] sub;
        logic wr_ch;
        off = bus_i.addr;
        ch = 2'h0;
        sub = off[3:0];
        wr_ch = 1'b0;
        s_d = s_q;
        s_d.ext_s1 = ext_timer_input_i;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_s3 = s_q.ext_s2;
        s_d.pre = s_q.pre + 8'h01;
        if (off >= tru_pkg::OFF_CH0
            && off < tru_pkg::OFF_CH0 + 8'(tru_pkg::NCH) * tru_pkg::CH_STRIDE)
        begin
            ch = 2'((off - tru_pkg::OFF_CH0) >> 4);
            wr_ch = 1'b1;
        end
        for (int i = 0; i < tru_pkg::NCH; i++) begin
            if (s_q.run[i] && tick[i]) begin
                s_d.cnt[i] = uflow_ev[i] ? s_q.rconst[i]
                    : s_q.cnt[i] - 32'h00000001;
            end
            if (uflow_ev[i]) begin
                s_d.ctrl[i][tru_pkg::B_UFLOW] = 1'b1;
            end
        end
        if (cap_ev) begin
            s_d.cap = s_q.cnt[2];
            s_d.ctrl[2][tru_pkg::B_CAPF] = 1'b1;
        end
        if (bus_i.wr) begin
            if (off == tru_pkg::OFF_RUN) begin
                s_d.run = bus_i.wdata[tru_pkg::NCH-1:0];
            end
            if (wr_ch) begin
                unique case (sub)
                    tru_pkg::SUB_CONST: s_d.rconst[ch] = bus_i.wdata;
                    tru_pkg::SUB_CNT: s_d.cnt[ch] = bus_i.wdata;
                    tru_pkg::SUB_CTRL: begin
                        s_d.ctrl[ch] = bus_i.wdata[15:0]
                            & ((ch == 2'h2) ? tru_pkg::CTRL2_MASK
                                            : tru_pkg::CTRL01_MASK);
                        // Writing 1 keeps a flag; a same-cycle set wins
                        s_d.ctrl[ch][tru_pkg::B_UFLOW] =
                            s_q.ctrl[ch][tru_pkg::B_UFLOW]
                            & bus_i.wdata[tru_pkg::B_UFLOW]
                            | uflow_ev[ch];
                        if (ch == 2'h2) begin
                            s_d.ctrl[2][tru_pkg::B_CAPF] =
                                s_q.ctrl[2][tru_pkg::B_CAPF]
                                & bus_i.wdata[tru_pkg::B_CAPF]
                                | cap_ev;
                        end
                    end
                    default: ;
                endcase
            end
        end
        s_d.rdata = 32'h00000000;
        if (bus_i.rd) begin
            if (off == tru_pkg::OFF_RUN) begin
                s_d.rdata = {29'h0, s_q.run};
            end else if (off == tru_pkg::OFF_CAP) begin
                s_d.rdata = s_q.cap;
            end else if (wr_ch) begin
                unique case (sub)
                    tru_pkg::SUB_CONST: s_d.rdata = s_q.rconst[ch];
                    tru_pkg::SUB_CNT: s_d.rdata = s_q.cnt[ch];
                    tru_pkg::SUB_CTRL: s_d.rdata = {16'h0, s_q.ctrl[ch]};
                    default: s_d.rdata = 32'h00000000;
                endcase
            end
        end
        for (int i = 0; i < tru_pkg::NCH; i++) begin
            s_d.uflow_irq[i] = s_d.ctrl[i][tru_pkg::B_UFLOW]
                & s_d.ctrl[i][tru_pkg::B_UFLOW_IE];
        end
        s_d.cap_irq = s_d.ctrl[2][tru_pkg::B_CAPF]
            & s_d.ctrl[2][tru_pkg::B_CAPE_HI]
            & s_d.ctrl[2][tru_pkg::B_CAPE_LO];
        if (mult_change_i || module_stop_i) begin
            s_d.run = '0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            s_q <= '0;
            s_q.rconst <= {tru_pkg::NCH{tru_pkg::CONST_RST}};
            s_q.cnt <= {tru_pkg::NCH{tru_pkg::CNT_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;
    assign underflow_irq_o = s_q.uflow_irq;
    assign capture_irq_o = s_q.cap_irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Channel 0 register addresses used by the checks
    localparam logic [7:0] CTL0_ADDR = tru_pkg::OFF_CH0
        + {4'h0, tru_pkg::SUB_CTRL};
    localparam logic [7:0] CNT0_ADDR = tru_pkg::OFF_CH0
        + {4'h0, tru_pkg::SUB_CNT};

    // Channel 0 ticking at zero with no bus write in the way
    sequence seq_uflow;
        s_q.run[0] && tick[0] && s_q.cnt[0] == tru_pkg::ZERO32 && !bus_i.wr;
    endsequence

    // Software writing the channel 0 control register
    sequence seq_ctl0_wr;
        bus_i.wr && bus_i.addr == CTL0_ADDR;
    endsequence

    // Channel 1 ticking above zero with no bus write in the way
    sequence seq_dec1;
        s_q.run[1] && tick[1] && s_q.cnt[1] != tru_pkg::ZERO32 && !bus_i.wr;
    endsequence

    // Pin edge taken while capture is enabled
    sequence seq_cap;
        cap_ev;
    endsequence

    AST_RELOAD: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_uflow |=> s_q.cnt[0] == $past(s_q.rconst[0]))
        else $error("counter did not reload");

    AST_UFLOW_SET: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_uflow |=> s_q.ctrl[0][tru_pkg::B_UFLOW])
        else $error("underflow flag not set");

    AST_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        !s_q.run[1] && !bus_i.wr |=> $stable(s_q.cnt[1]))
        else $error("halted counter moved");

    AST_DEC: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_dec1 |=> s_q.cnt[1] == $past(s_q.cnt[1]) - 32'h00000001)
        else $error("counter did not decrement");

    AST_IRQ: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        underflow_irq_o[0] == (s_q.ctrl[0][tru_pkg::B_UFLOW]
            && s_q.ctrl[0][tru_pkg::B_UFLOW_IE]))
        else $error("underflow irq mismatch");

    AST_CAP_IRQ: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        capture_irq_o == (s_q.ctrl[2][tru_pkg::B_CAPF]
            && s_q.ctrl[2][tru_pkg::B_CAPE_HI]
            && s_q.ctrl[2][tru_pkg::B_CAPE_LO]))
        else $error("capture irq mismatch");

    // Both stop causes must leave every channel halted
    AST_STOP: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        module_stop_i |=> s_q.run == 3'h0)
        else $error("run bits not cleared");

    AST_MULT: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        mult_change_i |=> s_q.run == 3'h0)
        else $error("run bits kept over multiplier change");

    AST_RSVD: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        s_q.ctrl[0][15:9] == 7'h00 && s_q.ctrl[1][7:6] == 2'h0)
        else $error("reserved bits set");

    AST_RSVD2: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        s_q.ctrl[2][15:10] == 6'h00)
        else $error("channel 2 reserved bits set");

    AST_RUN_RD: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        bus_i.rd && bus_i.addr == tru_pkg::OFF_RUN
        |=> rdata_o[31:3] == 29'h00000000)
        else $error("run register reserved bits read back");

    AST_CAP: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_cap |=> s_q.ctrl[2][tru_pkg::B_CAPF]
            && s_q.cap == $past(s_q.cnt[2]))
        else $error("capture missed");

    AST_EXT: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        s_q.ctrl[0][2:0] == tru_pkg::PSC_EXT
        && s_q.ctrl[0][4:3] == tru_pkg::EDGE_RISE && fall
        |-> !tick[0])
        else $error("falling edge counted");

    AST_WR: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        bus_i.wr && bus_i.addr == CNT0_ADDR
        |=> s_q.cnt[0] == $past(bus_i.wdata))
        else $error("counter write lost");

    // Writing a one must not disturb a set flag
    AST_FLAG_KEEP: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_ctl0_wr ##0 (bus_i.wdata[tru_pkg::B_UFLOW]
            && s_q.ctrl[0][tru_pkg::B_UFLOW])
        |=> s_q.ctrl[0][tru_pkg::B_UFLOW])
        else $error("flag lost on write of one");

    AST_FLAG_CLR: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        seq_ctl0_wr ##0 (!bus_i.wdata[tru_pkg::B_UFLOW] && !uflow_ev[0])
        |=> !s_q.ctrl[0][tru_pkg::B_UFLOW])
        else $error("flag not cleared by write of zero");

    // Fastest enable must come no more often than every fourth cycle
    AST_DIV: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        div_en[0] |=> (!div_en[0]) [*3])
        else $error("divide by four enable too frequent");

    AST_SYNC: assert property (
        @(posedge sys_clk_i) disable iff (srst_i)
        s_q.ext_s2 == $past(ext_timer_input_i, 2))
        else $error("pin synchroniser depth wrong");
endmodule

/* File: verilog/tru_pkg.sv */
// Package of constants and types for the three-channel reload timer
package tru_pkg;
    localparam int NCH = 3;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_RUN = 8'h00;
    localparam logic [7:0] OFF_CAP = 8'h04;
    localparam logic [7:0] OFF_CH0 = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] SUB_CONST = 4'h0;
    localparam logic [3:0] SUB_CNT = 4'h4;
    localparam logic [3:0] SUB_CTRL = 4'h8;
    // Control field positions
    localparam int B_CAPF = 9;
    localparam int B_UFLOW = 8;
    localparam int B_CAPE_HI = 7;
    localparam int B_CAPE_LO = 6;
    localparam int B_UFLOW_IE = 5;
    localparam int B_EDGE_HI = 4;
    localparam int B_EDGE_LO = 3;
    localparam int B_PSC_HI = 2;
    localparam logic [2:0] PSC_DIV4 = 3'h0;
    localparam logic [2:0] PSC_DIV16 = 3'h1;
    localparam logic [2:0] PSC_DIV64 = 3'h2;
    localparam logic [2:0] PSC_DIV256 = 3'h3;
    localparam logic [2:0] PSC_EXT = 3'h5;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [7:0] RUN_MASK = 8'h07;
    localparam logic [15:0] CTRL01_MASK = 16'h013F;
    localparam logic [15:0] CTRL2_MASK = 16'h03FF;
    localparam logic [31:0] CONST_RST = 32'hFFFFFFFF;
    localparam logic [31:0] CNT_RST = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO32 = 32'h00000000;
    localparam logic [7:0] PRE_DIV4_M = 8'h03;
    localparam logic [7:0] PRE_DIV16_M = 8'h0F;
    localparam logic [7:0] PRE_DIV64_M = 8'h3F;
    localparam logic [7:0] PRE_DIV256_M = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tru_bus_req_type;

    typedef struct packed {
        logic [NCH-1:0] run;
        logic [NCH-1:0][15:0] ctrl;
        logic [NCH-1:0][31:0] rconst;
        logic [NCH-1:0][31:0] cnt;
        logic [31:0] cap;
        logic [7:0] pre;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic [31:0] rdata;
        logic [NCH-1:0] uflow_irq;
        logic cap_irq;
    } tru_state_type;
endpackage

/* File: dv/tru_pin_model.sv */
// Drives the external timer input pin with whole pulses
`timescale 1ns/1ps
module tru_pin_model (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [3:0] npulse_i,
    output logic pin_o,
    output logic busy_o
);
    // Levels held 8 cycles, so the two-flop sync never misses an edge
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                repeat (npulse_i) begin
                    repeat (8) @(posedge sys_clk_i);
                    pin_o <= 1'b1;
                    repeat (8) @(posedge sys_clk_i);
                    pin_o <= 1'b0;
                end
                repeat (8) @(posedge sys_clk_i);
                busy_o <= 1'b0;
            end
        end
    end
endmodule

/* File: dv/tru_timer_tb.sv */
// Self-checking bench for the three-channel reload timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end
module three_channel_reload_timer_tb_top;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic mult_change = 1'b0;
    logic module_stop = 1'b0;
    logic pin_go = 1'b0;
    logic [3:0] pin_n = 4'h0;
    logic pin;
    logic pin_busy;
    tru_pkg::tru_bus_req_type bus = '0;
    logic [31:0] rdata;
    logic [2:0] uflow_irq;
    logic cap_irq;
    logic rd_d = 1'b0;
    logic [31:0] lfsr = 32'h00000007;
    logic [63:0] exp_q[$];
    int miscompares = 0;
    int check_count = 0;

    tru_timer dut (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .mult_change_i(mult_change),
        .module_stop_i(module_stop),
        .ext_timer_input_i(pin),
        .bus_i(bus),
        .rdata_o(rdata),
        .underflow_irq_o(uflow_irq),
        .capture_irq_o(cap_irq)
    );
    tru_pin_model pin_src (
        .sys_clk_i(sys_clk_i),
        .go_i(pin_go),
        .npulse_i(pin_n),
        .pin_o(pin),
        .busy_o(pin_busy)
    );
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // ------------------------------------------------
    // Bus tasks and helpers
    // ------------------------------------------------
    function automatic logic [7:0] ra(int c, logic [3:0] s);
        return tru_pkg::OFF_CH0 + 8'(c) * tru_pkg::CH_STRIDE + {4'h0, s};
    endfunction
    function automatic logic [7:0] ctl(int c);
        return ra(c, tru_pkg::SUB_CTRL);
    endfunction
    function automatic logic [7:0] cnt(int c);
        return ra(c, tru_pkg::SUB_CNT);
    endfunction
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] lo, logic [31:0] hi);
        @(posedge sys_clk_i);
        bus <= '{a, 32'h00000000, 1'b0, 1'b1};
        exp_q.push_back({lo, hi});
        @(posedge sys_clk_i);
        bus.rd <= 1'b0;
    endtask
    task automatic rdx(logic [7:0] a, logic [31:0] e);
        rd(a, e, e);
    endtask
    task automatic run(logic [31:0] v);
        wr(tru_pkg::OFF_RUN, v);
    endtask
    task automatic pulses(int n);
        int k = 0;
        @(posedge sys_clk_i);
        pin_go <= 1'b1;
        pin_n <= 4'(n);
        @(posedge sys_clk_i);
        pin_go <= 1'b0;
        @(posedge sys_clk_i);
        while (pin_busy && k < 400) begin
            @(posedge sys_clk_i);
            k++;
        end
        if (k >= 400) begin
            miscompares++;
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ------------------------------------------------
    // Read data monitor, oldest note first
    // ------------------------------------------------
    always @(posedge sys_clk_i) begin
        logic [63:0] e;
        if (rd_d && exp_q.size() == 0) `CHK("read note", 1'b1, 1'b0)
        else if (rd_d) begin
            e = exp_q.pop_front();
            if (e[63:32] == e[31:0]) `CHK("rdata", e[31:0], rdata)
            else `CHK("rdata range", 1'b1,
                (rdata >= e[63:32]) && (rdata <= e[31:0]))
        end
        rd_d <= bus.rd;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        end_sim();
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        int d;
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rdx(tru_pkg::OFF_RUN, 32'h00000000);
        rdx(tru_pkg::OFF_CAP, 32'h00000000);
        rdx(8'hFC, 32'h00000000);
        for (int c = 0; c < 3; c++) begin
            rdx(ra(c, tru_pkg::SUB_CONST), tru_pkg::CONST_RST);
            rdx(cnt(c), tru_pkg::CNT_RST);
            rdx(ctl(c), 32'h00000000);
        end
        // Reserved ones written on purpose; prohibited codes never
        wr(ctl(0), 32'h0000FFFD);
        rdx(ctl(0), 32'h0000003D);
        wr(ctl(2), 32'h0000FFFD);
        rdx(ctl(2), 32'h000000FD);
        run(32'h000000FF);
        rdx(tru_pkg::OFF_RUN, 32'h00000007);
        for (int i = 0; i < 2; i++) begin
            run(32'h00000007);
            @(posedge sys_clk_i);
            mult_change <= (i == 0);
            module_stop <= (i == 1);
            @(posedge sys_clk_i);
            mult_change <= 1'b0;
            module_stop <= 1'b0;
            rdx(tru_pkg::OFF_RUN, 32'h00000000);
        end
        wr(ctl(0), 32'h00000000);
        wr(ctl(2), 32'h00000000);
        for (int c = 0; c < 3; c++) begin
            for (int s = 0; s < 2; s++) begin
                lfsr = nxt(lfsr);
                wr(ra(c, s ? tru_pkg::SUB_CNT : tru_pkg::SUB_CONST), lfsr);
                rdx(ra(c, s ? tru_pkg::SUB_CNT : tru_pkg::SUB_CONST), lfsr);
            end
        end
        // Divider phase is free running, so a window of counts
        for (int p = 0; p < 4; p++) begin
            wr(ctl(0), 32'(p * 9));
            wr(cnt(0), 32'h00001000);
            run(32'h00000001);
            repeat (512) @(posedge sys_clk_i);
            run(32'h00000000);
            d = 4 << (2 * p);
            rd(cnt(0), 32'h00001000 - 32'(516 / d + 1),
                32'h00001000 - 32'(512 / d - 1));
        end
        for (int e = 0; e < 3; e++) begin
            wr(ctl(0), 32'h00000005 | 32'(e << 3));
            wr(cnt(0), 32'h00000100);
            run(32'h00000001);
            pulses(3);
            run(32'h00000000);
            pulses(2);
            rdx(cnt(0), 32'h00000100 - 32'((e == 2) ? 6 : 3));
        end
        wr(ra(0, tru_pkg::SUB_CONST), 32'h00000010);
        wr(cnt(0), 32'h00000001);
        wr(ctl(0), 32'h00000025);
        run(32'h00000001);
        pulses(3);
        `CHK("underflow irq", 3'b001, uflow_irq)
        rdx(cnt(0), 32'h0000000F);
        rdx(ctl(0), 32'h00000125);
        wr(ctl(0), 32'h00000105);
        repeat (3) @(posedge sys_clk_i);
        `CHK("masked irq", 3'b000, uflow_irq)
        rdx(ctl(0), 32'h00000105);
        wr(ctl(0), 32'h00000025);
        repeat (3) @(posedge sys_clk_i);
        `CHK("cleared irq", 3'b000, uflow_irq)
        rdx(ctl(0), 32'h00000025);
        run(32'h00000000);
        wr(cnt(2), 32'h00000050);
        wr(ctl(2), 32'h000000C3);
        pulses(1);
        `CHK("capture irq", 1'b1, cap_irq)
        rdx(tru_pkg::OFF_CAP, 32'h00000050);
        rdx(ctl(2), 32'h000002C3);
        wr(ctl(2), 32'h00000083);
        rdx(ctl(2), 32'h00000083);
        wr(cnt(2), 32'h00000060);
        pulses(1);
        rdx(tru_pkg::OFF_CAP, 32'h00000060);
        `CHK("capture irq off", 1'b0, cap_irq)
        rdx(ctl(2), 32'h00000283);
        repeat (4) @(posedge sys_clk_i);
        end_sim();
    end
endmodule
